// ---- include/ehc_pkg.sv ----
// Constants, timing counts and state type of the page-write host controller
`default_nettype none
package ehc_pkg;
   // ****************************************************
   // Pin and field layout
   // ****************************************************
   localparam int ADDR_W     = 15;   // Address pins
   localparam int DATA_W     = 8;    // Data pins
   localparam int PAGE_LSB   = 6;    // Lowest page address bit
   localparam int OFF_W      = 6;    // Byte offset inside a page
   localparam int PAGE_W     = 9;    // Page address bits
   localparam int PAGE_BYTES = 64;   // Bytes in one page
   localparam int TOGGLE_BIT = 6;    // Toggle status line position
   localparam int UNLOCK_N   = 3;    // Writes in the unlock sequence
   localparam int CNT_W      = 16;   // Phase and timeout counter width
   // ****************************************************
   // Times and the cycle counts derived from them
   // ****************************************************
   localparam int CLK_KHZ    = 10000;  // 10 MHz clock
   localparam int T_WP_NS    = 100;    // Least write pulse width
   localparam int T_WPH_NS   = 50;     // Least write pulse high time
   localparam int T_ACC_NS   = 120;    // Longest access time
   localparam int T_OEHP_NS  = 150;    // Least gate high pulse in polling
   localparam int T_WC_MS    = 3;      // Longest internal write time
   localparam int SYNC_STAGES = 2;     // Input synchroniser depth
   localparam int WP_CYC   = (T_WP_NS * CLK_KHZ + 999999) / 1000000;
   localparam int WPH_CYC  = (T_WPH_NS * CLK_KHZ + 999999) / 1000000;
   localparam int ACC_CYC  = (T_ACC_NS * CLK_KHZ + 999999) / 1000000;
   localparam int OEHP_CYC = (T_OEHP_NS * CLK_KHZ + 999999) / 1000000;
   localparam int RD_CYC   = ACC_CYC + SYNC_STAGES;  // Access plus sync
   localparam int WC_CYC   = T_WC_MS * CLK_KHZ;      // Polling limit
   // ****************************************************
   // Values after reset
   // ****************************************************
   localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
   // ****************************************************
   // Controller states
   // ****************************************************
   typedef enum logic [2:0] {
      EHC_IDLE,       // Waiting for a start
      EHC_WR_SETUP,   // Address and data out, strobes high
      EHC_WR_STROBE,  // Chip select and write strobe low
      EHC_WR_RECOV,   // Strobes high again
      EHC_FETCH,      // Page buffer read under way
      EHC_RD_ACCESS,  // Polling read, select and gate low
      EHC_RD_GAP      // Gate high pulse between polling reads
   } ehc_state_e;
endpackage
`default_nettype wire

// ---- include/ehc_buf_if.sv ----
// Carrier between the controller and its page buffer
`default_nettype none
interface ehc_buf_if;
   logic                        we;     // Write strobe into the buffer
   logic [ehc_pkg::OFF_W-1:0]   waddr;  // Write offset
   logic [ehc_pkg::DATA_W-1:0]  wdata;  // Write byte
   logic [ehc_pkg::OFF_W-1:0]   raddr;  // Read offset
   logic [ehc_pkg::DATA_W-1:0]  rdata;  // Registered read byte
   modport ctrl (output we, output waddr, output wdata, output raddr,
                 input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface
`default_nettype wire

// ---- logic/ehc_page_buf.sv ----
// Page buffer memory with registered read data
`default_nettype none
module ehc_page_buf #(
   parameter int DEPTH = ehc_pkg::PAGE_BYTES
) (
   input  wire logic  clk_i,
   ehc_buf_if.mem     bus
);
   // Storage array
   logic [ehc_pkg::DATA_W-1:0] mem_reg [DEPTH];
   // Read data register
   logic [ehc_pkg::DATA_W-1:0] rdata_reg;

   // ****************************************************
   // Write and registered read
   // ****************************************************
   always_ff @(posedge clk_i)
   begin
      if (bus.we)
      begin
         mem_reg[bus.waddr] <= bus.wdata;
      end
      rdata_reg <= mem_reg[bus.raddr];
   end

   assign bus.rdata = rdata_reg;
endmodule
`default_nettype wire

// ---- logic/ehc_ctrl.sv ----
// Host controller for protected page write and toggle status polling
`default_nettype none
// How it works
// - Keep one page address through page load
// - Output gate high while write strobes low
// - Judge completion by comparing successive reads
// - Poll one constant address until finished or timed out
module ehc_ctrl #(
   parameter int                            WC_TIMEOUT = ehc_pkg::WC_CYC,
   parameter logic [ehc_pkg::ADDR_W-1:0]    UNL_A0 = 15'h0001,
   parameter logic [ehc_pkg::ADDR_W-1:0]    UNL_A1 = 15'h0002,
   parameter logic [ehc_pkg::ADDR_W-1:0]    UNL_A2 = 15'h0001,
   parameter logic [ehc_pkg::DATA_W-1:0]    UNL_D0 = 8'h01,
   parameter logic [ehc_pkg::DATA_W-1:0]    UNL_D1 = 8'h02,
   parameter logic [ehc_pkg::DATA_W-1:0]    UNL_D2 = 8'h03
) (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         buf_wr_i,
   input  wire logic [ehc_pkg::OFF_W-1:0]    buf_addr_i,
   input  wire logic [ehc_pkg::DATA_W-1:0]   buf_data_i,
   input  wire logic                         start_i,
   input  wire logic                         unlock_i,
   input  wire logic [ehc_pkg::PAGE_W-1:0]   page_i,
   input  wire logic [ehc_pkg::OFF_W-1:0]    last_i,
   input  wire logic [ehc_pkg::ADDR_W-1:0]   poll_addr_i,
   input  wire logic [ehc_pkg::DATA_W-1:0]   dq_i,
   output logic [ehc_pkg::ADDR_W-1:0]        addr_o,
   output logic [ehc_pkg::DATA_W-1:0]        dq_o,
   output logic                              dq_oe_n_o,
   output logic                              ce_n_o,
   output logic                              oe_n_o,
   output logic                              we_n_o,
   output logic                              busy_o,
   output logic                              done_o,
   output logic                              timeout_o,
   output logic [ehc_pkg::DATA_W-1:0]        poll_data_o
);
   // ****************************************************
   // Declarations
   // ****************************************************
   ehc_buf_if                        buf_bus ();     // Buffer carrier
   ehc_pkg::ehc_state_e              state_reg;      // Current state
   ehc_pkg::ehc_state_e              state_next;
   logic [ehc_pkg::CNT_W-1:0]        cnt_reg;        // Phase counter
   logic [ehc_pkg::CNT_W-1:0]        cnt_next;
   logic [ehc_pkg::CNT_W-1:0]        tmo_reg;        // Polling time
   logic [ehc_pkg::CNT_W-1:0]        tmo_next;
   logic [ehc_pkg::OFF_W-1:0]        idx_reg;        // Byte or code index
   logic [ehc_pkg::OFF_W-1:0]        idx_next;
   logic                             unl_reg;        // In unlock sequence
   logic                             unl_next;
   logic [ehc_pkg::PAGE_W-1:0]       page_reg;       // Latched page
   logic [ehc_pkg::PAGE_W-1:0]       page_next;
   logic [ehc_pkg::OFF_W-1:0]        last_reg;       // Latched last offset
   logic [ehc_pkg::OFF_W-1:0]        last_next;
   logic [ehc_pkg::ADDR_W-1:0]       paddr_reg;      // Latched poll address
   logic [ehc_pkg::ADDR_W-1:0]       paddr_next;
   logic                             have_reg;       // Previous read held
   logic                             have_next;
   logic                             prev_reg;       // Previous status bit
   logic                             prev_next;
   logic [ehc_pkg::ADDR_W-1:0]       addr_reg;       // Address pins
   logic [ehc_pkg::ADDR_W-1:0]       addr_next;
   logic [ehc_pkg::DATA_W-1:0]       dq_reg;         // Data pins out
   logic [ehc_pkg::DATA_W-1:0]       dq_next;
   logic                             dq_oe_n_reg;    // Data drive, low on
   logic                             dq_oe_n_next;
   logic                             ce_n_reg;       // Chip select pin
   logic                             ce_n_next;
   logic                             oe_n_reg;       // Output gate pin
   logic                             oe_n_next;
   logic                             we_n_reg;       // Write strobe pin
   logic                             we_n_next;
   logic                             busy_reg;       // Operation running
   logic                             busy_next;
   logic                             done_reg;       // Completion pulse
   logic                             done_next;
   logic                             tmo_hit_reg;    // Timeout pulse
   logic                             tmo_hit_next;
   logic [ehc_pkg::DATA_W-1:0]       pdata_reg;      // Last polled byte
   logic [ehc_pkg::DATA_W-1:0]       pdata_next;
   logic [ehc_pkg::DATA_W-1:0]       dq_s1_reg;      // Sync first stage
   logic [ehc_pkg::DATA_W-1:0]       dq_s2_reg;      // Sync second stage

   // Unlock code address by step
   function automatic logic [ehc_pkg::ADDR_W-1:0] unl_addr(
      input logic [ehc_pkg::OFF_W-1:0] i);
      unl_addr = (i == 6'h00) ? UNL_A0 : (i == 6'h01) ? UNL_A1 : UNL_A2;
   endfunction

   // Unlock code data by step
   function automatic logic [ehc_pkg::DATA_W-1:0] unl_data(
      input logic [ehc_pkg::OFF_W-1:0] i);
      unl_data = (i == 6'h00) ? UNL_D0 : (i == 6'h01) ? UNL_D1 : UNL_D2;
   endfunction

   // ****************************************************
   // Page buffer
   // ****************************************************
   assign buf_bus.we    = buf_wr_i;
   assign buf_bus.waddr = buf_addr_i;
   assign buf_bus.wdata = buf_data_i;
   assign buf_bus.raddr = idx_reg;

   ehc_page_buf #(
      .DEPTH (ehc_pkg::PAGE_BYTES)
   ) u_buf (
      .clk_i (clk_i),
      .bus   (buf_bus.mem)
   );

   // ****************************************************
   // Data pin synchroniser
   // ****************************************************
   always_ff @(posedge clk_i)
   begin
      dq_s1_reg <= dq_i;
      dq_s2_reg <= dq_s1_reg;
   end

   // ****************************************************
   // Sequencer next state
   // ****************************************************
   always_comb
   begin
      state_next   = state_reg;
      cnt_next     = cnt_reg + 16'h0001;
      tmo_next     = tmo_reg;
      idx_next     = idx_reg;
      unl_next     = unl_reg;
      page_next    = page_reg;
      last_next    = last_reg;
      paddr_next   = paddr_reg;
      have_next    = have_reg;
      prev_next    = prev_reg;
      addr_next    = addr_reg;
      dq_next      = dq_reg;
      dq_oe_n_next = dq_oe_n_reg;
      ce_n_next    = ce_n_reg;
      oe_n_next    = oe_n_reg;
      we_n_next    = we_n_reg;
      busy_next    = busy_reg;
      done_next    = 1'b0;
      tmo_hit_next = 1'b0;
      pdata_next   = pdata_reg;
      case (state_reg)
         ehc_pkg::EHC_IDLE:
         begin
            // Latch the job, unlock first when asked
            if (start_i)
            begin
               page_next  = page_i;
               last_next  = last_i;
               paddr_next = poll_addr_i;
               unl_next   = unlock_i;
               idx_next   = 6'h00;
               busy_next  = 1'b1;
               cnt_next   = ehc_pkg::CNT_RST;
               state_next = unlock_i ? ehc_pkg::EHC_WR_SETUP
                                     : ehc_pkg::EHC_FETCH;
            end
         end
         ehc_pkg::EHC_FETCH:
         begin
            // Buffer byte appears next cycle
            cnt_next   = ehc_pkg::CNT_RST;
            state_next = ehc_pkg::EHC_WR_SETUP;
         end
         ehc_pkg::EHC_WR_SETUP:
         begin
            // Address and data settle, gate stays high
            if (unl_reg)
            begin
               addr_next = unl_addr(idx_reg);
               dq_next   = unl_data(idx_reg);
            end
            else
            begin
               addr_next = {page_reg, idx_reg};
               dq_next   = buf_bus.rdata;
            end
            dq_oe_n_next = 1'b0;
            oe_n_next    = 1'b1;
            cnt_next     = ehc_pkg::CNT_RST;
            state_next   = ehc_pkg::EHC_WR_STROBE;
         end
         ehc_pkg::EHC_WR_STROBE:
         begin
            // Select and strobe low for the pulse width
            ce_n_next = 1'b0;
            we_n_next = 1'b0;
            if (cnt_reg == 16'(ehc_pkg::WP_CYC))
            begin
               ce_n_next  = 1'b1;
               we_n_next  = 1'b1;
               cnt_next   = ehc_pkg::CNT_RST;
               state_next = ehc_pkg::EHC_WR_RECOV;
            end
         end
         ehc_pkg::EHC_WR_RECOV:
         begin
            // Strobes high before the next load
            if (cnt_reg == 16'(ehc_pkg::WPH_CYC - 1))
            begin
               cnt_next = ehc_pkg::CNT_RST;
               if (unl_reg && idx_reg == 6'(ehc_pkg::UNLOCK_N - 1))
               begin
                  // Codes done, page load follows
                  unl_next   = 1'b0;
                  idx_next   = 6'h00;
                  state_next = ehc_pkg::EHC_FETCH;
               end
               else if (unl_reg)
               begin
                  idx_next   = idx_reg + 6'h01;
                  state_next = ehc_pkg::EHC_WR_SETUP;
               end
               else if (idx_reg == last_reg)
               begin
                  // Page loaded, start polling one address
                  dq_oe_n_next = 1'b1;
                  have_next    = 1'b0;
                  tmo_next     = ehc_pkg::CNT_RST;
                  addr_next    = paddr_reg;
                  ce_n_next    = 1'b0;
                  oe_n_next    = 1'b0;
                  state_next   = ehc_pkg::EHC_RD_ACCESS;
               end
               else
               begin
                  idx_next   = idx_reg + 6'h01;
                  state_next = ehc_pkg::EHC_FETCH;
               end
            end
         end
         ehc_pkg::EHC_RD_ACCESS:
         begin
            // Read strobe by gate and select together
            tmo_next = tmo_reg + 16'h0001;
            if (cnt_reg == 16'(ehc_pkg::RD_CYC - 1))
            begin
               ce_n_next  = 1'b1;
               oe_n_next  = 1'b1;
               cnt_next   = ehc_pkg::CNT_RST;
               pdata_next = dq_s2_reg;
               prev_next  = dq_s2_reg[ehc_pkg::TOGGLE_BIT];
               have_next  = 1'b1;
               // Equal toggle bits in two reads in a row mean finished
               if (have_reg &&
                   dq_s2_reg[ehc_pkg::TOGGLE_BIT] == prev_reg)
               begin
                  done_next  = 1'b1;
                  busy_next  = 1'b0;
                  state_next = ehc_pkg::EHC_IDLE;
               end
               else
               begin
                  state_next = ehc_pkg::EHC_RD_GAP;
               end
            end
            else if (tmo_reg >= 16'(WC_TIMEOUT - 1))
            begin
               // Write never finished
               ce_n_next    = 1'b1;
               oe_n_next    = 1'b1;
               tmo_hit_next = 1'b1;
               busy_next    = 1'b0;
               state_next   = ehc_pkg::EHC_IDLE;
            end
         end
         ehc_pkg::EHC_RD_GAP:
         begin
            // Gate high pulse, address unchanged
            tmo_next = tmo_reg + 16'h0001;
            if (cnt_reg == 16'(ehc_pkg::OEHP_CYC - 1))
            begin
               ce_n_next  = 1'b0;
               oe_n_next  = 1'b0;
               cnt_next   = ehc_pkg::CNT_RST;
               state_next = ehc_pkg::EHC_RD_ACCESS;
            end
         end
         default:
         begin
            state_next = ehc_pkg::EHC_IDLE;
         end
      endcase
   end

   // ****************************************************
   // Sequencer registers
   // ****************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg   <= ehc_pkg::EHC_IDLE;
         cnt_reg     <= ehc_pkg::CNT_RST;
         tmo_reg     <= ehc_pkg::CNT_RST;
         idx_reg     <= 6'h00;
         unl_reg     <= 1'b0;
         page_reg    <= 9'h000;
         last_reg    <= 6'h00;
         paddr_reg   <= ehc_pkg::ADDR_RST;
         have_reg    <= 1'b0;
         prev_reg    <= 1'b0;
         addr_reg    <= ehc_pkg::ADDR_RST;
         dq_reg      <= ehc_pkg::DATA_RST;
         dq_oe_n_reg <= 1'b1;
         ce_n_reg    <= 1'b1;
         oe_n_reg    <= 1'b1;
         we_n_reg    <= 1'b1;
         busy_reg    <= 1'b0;
         done_reg    <= 1'b0;
         tmo_hit_reg <= 1'b0;
         pdata_reg   <= ehc_pkg::DATA_RST;
      end
      else
      begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         tmo_reg     <= tmo_next;
         idx_reg     <= idx_next;
         unl_reg     <= unl_next;
         page_reg    <= page_next;
         last_reg    <= last_next;
         paddr_reg   <= paddr_next;
         have_reg    <= have_next;
         prev_reg    <= prev_next;
         addr_reg    <= addr_next;
         dq_reg      <= dq_next;
         dq_oe_n_reg <= dq_oe_n_next;
         ce_n_reg    <= ce_n_next;
         oe_n_reg    <= oe_n_next;
         we_n_reg    <= we_n_next;
         busy_reg    <= busy_next;
         done_reg    <= done_next;
         tmo_hit_reg <= tmo_hit_next;
         pdata_reg   <= pdata_next;
      end
   end

   // ****************************************************
   // Outputs straight from flops
   // ****************************************************
   assign addr_o      = addr_reg;
   assign dq_o        = dq_reg;
   assign dq_oe_n_o   = dq_oe_n_reg;
   assign ce_n_o      = ce_n_reg;
   assign oe_n_o      = oe_n_reg;
   assign we_n_o      = we_n_reg;
   assign busy_o      = busy_reg;
   assign done_o      = done_reg;
   assign timeout_o   = tmo_hit_reg;
   assign poll_data_o = pdata_reg;
endmodule
`default_nettype wire

// ---- tb/ehc_ctrl_properties.sv ----
// Pin-level checker of the page-write host controller
`default_nettype none
module ehc_ctrl_properties (
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire logic                       start_i,
   input wire logic                       unlock_i,
   input wire logic [ehc_pkg::PAGE_W-1:0] page_i,
   input wire logic [ehc_pkg::ADDR_W-1:0] poll_addr_i,
   input wire logic [ehc_pkg::ADDR_W-1:0] addr_o,
   input wire logic                       dq_oe_n_o,
   input wire logic                       ce_n_o,
   input wire logic                       oe_n_o,
   input wire logic                       we_n_o,
   input wire logic                       busy_o,
   input wire logic                       done_o
);
   // ********************
   // Job capture
   // ********************
   logic [ehc_pkg::PAGE_W-1:0] pg_reg, pg_next;     // Page of the job
   logic [ehc_pkg::ADDR_W-1:0] poll_reg, poll_next; // Polling address
   logic                       ul_reg, ul_next;     // Unlock codes first
   logic [1:0]                 n_reg, n_next;       // Strobes seen, capped
   logic                       we_reg, we_next;     // Strobe a cycle back
   logic                       fall;                // Strobe falls now
   // Next values of the capture
   always_comb
   begin
      fall      = we_reg & ~we_n_o;
      we_next   = we_n_o;
      pg_next   = pg_reg;
      poll_next = poll_reg;
      ul_next   = ul_reg;
      n_next    = (fall && n_reg != 2'h3) ? n_reg + 2'h1 : n_reg;
      if (start_i && !busy_o)
      begin
         pg_next   = page_i;
         poll_next = poll_addr_i;
         ul_next   = unlock_i;
         n_next    = 2'h0;
      end
   end
   // Registers of the capture
   always_ff @(posedge clk_i)
   begin
      pg_reg   <= rst_i ? 9'h000 : pg_next;
      poll_reg <= rst_i ? 15'h0000 : poll_next;
      ul_reg   <= rst_i ? 1'h0 : ul_next;
      n_reg    <= rst_i ? 2'h0 : n_next;
      we_reg   <= rst_i ? 1'h1 : we_next;
   end
   // ********************
   // Properties
   // ********************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Strobe low one cycle, gate high, address steady, then release
   sequence s_strobe;
      (!we_n_o && !ce_n_o && oe_n_o) ##1
      (we_n_o && ce_n_o && $stable(addr_o));
   endsequence
   property p_gate_high;
      (!we_n_o && !ce_n_o) |-> oe_n_o;
   endproperty
   a_gate_high: assert property (p_gate_high)
      else $error("gate low during a write strobe");
   property p_write_pulse;
      $fell(we_n_o) |-> s_strobe;
   endproperty
   a_write_pulse: assert property (p_write_pulse)
      else $error("write strobe shape broken");
   property p_page_fixed;
      (fall && (!ul_reg || n_reg == 2'h3)) |->
         addr_o[ehc_pkg::ADDR_W-1:ehc_pkg::PAGE_LSB] == pg_reg;
   endproperty
   a_page_fixed: assert property (p_page_fixed)
      else $error("page bits differ at a strobe");
   property p_poll_addr;
      (!oe_n_o && !ce_n_o) |-> (addr_o == poll_reg && dq_oe_n_o);
   endproperty
   a_poll_addr: assert property (p_poll_addr)
      else $error("polling read at another address");
   property p_read_hold;
      (!oe_n_o && $past(!oe_n_o)) |-> $stable(addr_o);
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("address moved inside a read");
   property p_gap;
      ($rose(oe_n_o) && busy_o) |-> oe_n_o[*2];
   endproperty
   a_gap: assert property (p_gap)
      else $error("gate high pulse too short");
   property p_done;
      done_o |-> ($past(!oe_n_o) && oe_n_o && ce_n_o && !busy_o);
   endproperty
   a_done: assert property (p_done)
      else $error("done not at the end of a read");
endmodule
bind ehc_ctrl ehc_ctrl_properties u_props (
   .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
   .unlock_i(unlock_i), .page_i(page_i), .poll_addr_i(poll_addr_i),
   .addr_o(addr_o), .dq_oe_n_o(dq_oe_n_o), .ce_n_o(ce_n_o),
   .oe_n_o(oe_n_o), .we_n_o(we_n_o), .busy_o(busy_o), .done_o(done_o)
);
`default_nettype wire

// ---- tb/ehc_mem_model.sv ----
// Behavioural model of the byte-wide memory behind the controller
`default_nettype none
module ehc_mem_model (
   input  wire logic [ehc_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [ehc_pkg::DATA_W-1:0] din_i,
   input  wire logic                       din_oe_n_i,
   input  wire logic                       ce_n_i,
   input  wire logic                       oe_n_i,
   input  wire logic                       we_n_i,
   output logic      [ehc_pkg::DATA_W-1:0] dout_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [ehc_pkg::DATA_W-1:0] mem [int];  // Stored bytes
   logic [ehc_pkg::DATA_W-1:0] cur;        // Byte at the read address
   int   busy_reads = 0;                   // Reads a write stays busy
   int   busy_cnt   = 0;                   // Reads left in this write
   logic tog        = 1'h0;                // Toggle status level
   wire  wr_n = ce_n_i | we_n_i;           // Write strobe pair
   wire  rd_n = ce_n_i | oe_n_i | ~we_n_i; // Read strobe pair
   initial dout_o = 8'h5A;
   // Byte taken as the strobe pair rises; restarts the write timer
   always @(posedge wr_n)
      if (oe_n_i && !din_oe_n_i)
      begin
         mem[addr_i] = din_i;
         busy_cnt    = busy_reads;
      end
   // A read with select and gate both low and the write strobe high advances the status
   always @(negedge rd_n)
      if (busy_cnt > 0)
      begin
         tog      = ~tog;
         busy_cnt = busy_cnt - 1;
      end
   // Status byte while busy, stored byte after; churn when released
   always @(rd_n or addr_i or busy_cnt or tog)
      if (!rd_n)
      begin
         cur    = mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
         dout_o = (busy_cnt > 0) ? {~cur[7], tog, ~cur[5:0]} : cur;
      end
      else
         dout_o = ~dout_o;
endmodule
`default_nettype wire

// ---- tb/ehc_ctrl_tb.sv ----
// Self-checking bench of the page-write host controller
`default_nettype none
module ehc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TO = 200;         // Shortened polling limit
   logic       clk_i = 1'h0;        // 10 MHz clock
   logic       rst_i = 1'h1;        // Synchronous reset
   logic       buf_wr = 1'h0, start = 1'h0, unlock = 1'h0;
   logic [5:0] buf_addr = 6'h00, last = 6'h00;
   logic [7:0] buf_data = 8'h00, dq_i, dq_o, poll_data;
   logic [8:0] page = 9'h000, e;
   logic [14:0] poll_addr = 15'h0000, addr;
   logic       dq_oe_n, ce_n, oe_n, we_n, busy_o, done_o, timeout_o;
   logic [7:0] data [64];           // Bytes of the current job
   logic [8:0] exp_q [$];           // Expected {timeout, byte}
   int         err_total = 0;
   int         n_compared = 0;
   always #50 clk_i = ~clk_i;
   ehc_ctrl #(.WC_TIMEOUT(TO)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .buf_wr_i(buf_wr),
      .buf_addr_i(buf_addr), .buf_data_i(buf_data), .start_i(start),
      .unlock_i(unlock), .page_i(page), .last_i(last),
      .poll_addr_i(poll_addr), .dq_i(dq_i), .addr_o(addr), .dq_o(dq_o),
      .dq_oe_n_o(dq_oe_n), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
      .busy_o(busy_o), .done_o(done_o), .timeout_o(timeout_o),
      .poll_data_o(poll_data));
   ehc_mem_model dev (
      .addr_i(addr), .din_i(dq_o), .din_oe_n_i(dq_oe_n), .ce_n_i(ce_n),
      .oe_n_i(oe_n), .we_n_i(we_n), .dout_o(dq_i));
   // Compare and count
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic wrap_up;
      if (err_total == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Load, start, refuse a second start, wait, check stored page
   task automatic job(input logic ul, input int nb, input logic [5:0] ls);
      logic [8:0] pg;
      logic [5:0] po;
      int i;
      pg = 9'(1 + $urandom % 511);
      for (i = 0; i <= int'(ls); i++)
      begin
         data[i]  = 8'($urandom);
         buf_addr = 6'(i);
         buf_data = data[i];
         buf_wr   = 1'h1;
         @(negedge clk_i);
      end
      buf_wr = 1'h0;
      po = 6'($urandom % (int'(ls) + 1));
      dev.busy_reads = nb;
      dev.tog = 1'($urandom);
      page = pg;
      last = ls;
      unlock = ul;
      poll_addr = {pg, po};
      start = 1'h1;
      exp_q.push_back({nb > 100, data[po]});
      @(negedge clk_i);
      start = 1'h0;
      repeat (3) @(negedge clk_i);
      page = ~pg;
      start = 1'h1;
      @(negedge clk_i);
      start = 1'h0;
      for (i = 0; i < 3000 && busy_o !== 1'h0; i++)
         @(negedge clk_i);
      check("busy after job", 16'(busy_o), 16'h0000);
      for (i = 0; i <= int'(ls); i++)
         check("stored byte", dev.mem[int'({pg, 6'(i)})], data[i]);
   endtask
   // Result watcher: oldest note against what the controller reports
   always @(negedge clk_i)
      if (done_o === 1'h1 || timeout_o === 1'h1)
      begin
         if (exp_q.size() == 0)
            check("result count", 16'h0001, 16'h0000);
         else
         begin
            e = exp_q.pop_front();
            check("timeout", timeout_o, e[8]);
            if (!e[8])
               check("poll data", poll_data, e[7:0]);
         end
      end
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      wrap_up();
   end
   // Main sequence
   initial
   begin
      void'($urandom(93855));
      repeat (16) @(negedge clk_i);
      rst_i = 1'h0;
      @(negedge clk_i);
      job(1'h0, 3, 6'h00);
      job(1'h1, 0, 6'h3F);
      job(1'h1, 5, 6'($urandom));
      job(1'h0, 1000, 6'($urandom));
      job(1'h0, 1, 6'($urandom));
      job(1'h1, 8, 6'($urandom));
      repeat (4) @(negedge clk_i);
      check("results left", 16'(exp_q.size()), 16'h0000);
      wrap_up();
   end
endmodule
`default_nettype wire
